// *** hdl/ebcs_defines.vh ***
// offsets, field positions, reset values and timing counts of the bus cycle sequencer
`ifndef EBCS_DEFINES_VH
`define EBCS_DEFINES_VH

// register byte offsets
`define EBCS_OFF_ADDR      8'h00
`define EBCS_OFF_WDATA     8'h04
`define EBCS_OFF_CMD       8'h08
`define EBCS_OFF_RDATA     8'h0c
`define EBCS_OFF_STATUS    8'h10
`define EBCS_OFF_CTRL      8'h14
`define EBCS_OFF_TIMING    8'h20

// command register fields
`define EBCS_CMD_WRITE     0
`define EBCS_CMD_CS_LSB    1
`define EBCS_CMD_BYTE      3

// control register fields
`define EBCS_CTRL_MUX      0
`define EBCS_CTRL_RDY_LOW  1
`define EBCS_CTRL_CLK_SYS  2
`define EBCS_CTRL_HS_DRV   3
`define EBCS_CTRL_RST      4'h0

// timing configuration fields
`define EBCS_T_AB          0
`define EBCS_T_ABX_MSB     2
`define EBCS_T_ABX_LSB     1
`define EBCS_T_CMD_MSB     4
`define EBCS_T_CMD_LSB     3
`define EBCS_T_WS          5
`define EBCS_T_ACC_MSB     10
`define EBCS_T_ACC_LSB     6
`define EBCS_T_HOLD_MSB    12
`define EBCS_T_HOLD_LSB    11
`define EBCS_T_RDY_EN      13
`define EBCS_T_RDY_ASYNC   14
`define EBCS_TIMING_RST    15'h08c9

// system clock periods per phase time unit
`define EBCS_TCS_DIV       1

`endif

// *** hdl/ebcs_sync2.v ***
// two-stage synchroniser for the asynchronous ready input
`timescale 1ns/10ps
module ebcs_sync2 (
	// clock and reset
	input  wire clk_i,
	input  wire resetn_i,
	// level in and out
	input  wire async_i,
	output reg  sync_o
);

	reg meta_reg;

	// first stage feeds only the second
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_reg <= 1'b0;
			sync_o   <= 1'b0;
		end else begin
			meta_reg <= async_i;
			sync_o   <= meta_reg;
		end
	end

endmodule // ebcs_sync2

// *** hdl/ebcs_top.v ***
// external bus cycle sequencer: five-phase cycles, ready handshake, register port
// Operation
// - every bus cycle runs address setup, command delay, write setup, access, hold
// - phase lengths come from the timing configuration of the selected chip select
// - ready input may optionally stretch the access phase; partner drives it
// - address setup lasts 1 or 2 units, plus 0 to 3 on window change
// - command delay 0 to 3 units, then write setup or tristate 0 to 1
// - access phase lasts 1 to 32 units before ready extension
// - hold phase of 0 to 3 units closes each cycle
// - read data captured on the edge that ends the read strobe
// - address changes after strobe end do not disturb captured read data
// - multiplexed mode: address then write data on shared 16-bit lines
// - split mode: 24-bit address lines and separate 16-bit data lines
// - reference clock enabled when system clock source and fast driver selected
// - ready active polarity selectable by configuration
// - synchronous ready sampled directly, partner keeps it synchronous
// - asynchronous ready goes through synchroniser, at least one wait state
// - each ready sample: inactive inserts wait state, active ends access phase
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "ebcs_defines.vh"
module ebcs_top #(
	parameter NCS     = 4,
	parameter CSW     = 2,
	parameter TCS_DIV = `EBCS_TCS_DIV
) (
	// clock and reset
	input  wire             clk_i,
	input  wire             resetn_i,
	// register port
	input  wire [7:0]       addr_i,
	input  wire [31:0]      wdata_i,
	input  wire             wr_i,
	input  wire             rd_i,
	output reg  [31:0]      rdata_o,
	// external bus outputs
	output reg  [23:0]      address_lines_o,
	output reg  [15:0]      separate_data_lines_o,
	output reg              separate_data_lines_oe_n_o,
	output reg  [15:0]      shared_addr_data_lines_o,
	output reg              shared_addr_data_lines_oe_n_o,
	output reg  [NCS-1:0]   cs_n_o,
	output reg              rd_n_o,
	output reg              wr_n_o,
	output reg              ale_o,
	output reg              upper_byte_enable_n_o,
	output reg              reference_clock_out_en_o,
	// external bus inputs
	input  wire [15:0]      separate_data_lines_i,
	input  wire [15:0]      shared_addr_data_lines_i,
	input  wire             ready_i
);

	// phase states
	localparam ST_IDLE = 3'h0;
	localparam ST_AB   = 3'h1;
	localparam ST_C    = 3'h2;
	localparam ST_D    = 3'h3;
	localparam ST_E    = 3'h4;
	localparam ST_RDY  = 3'h5;
	localparam ST_F    = 3'h6;

	// timing window base, named so its index bits can be sliced
	localparam [7:0] TIM_BASE = `EBCS_OFF_TIMING;

	reg  [2:0]  state_reg;
	reg  [2:0]  state_next;
	reg  [5:0]  cnt_reg;
	reg  [5:0]  cnt_next;
	reg  [15:0] tick_cnt_reg;
	reg         tick_reg;
	reg  [14:0] timing_reg [0:NCS-1];
	reg  [14:0] cfg_reg;
	reg  [3:0]  ctrl_reg;
	reg  [23:0] addr_reg;
	reg  [15:0] wdata_reg;
	reg  [15:0] rdata_reg;
	reg         dir_wr_reg;
	reg         byte_reg;
	reg  [CSW-1:0] cs_reg;
	reg  [CSW-1:0] last_cs_reg;
	reg         last_valid_reg;
	wire        rdy_sync;
	integer     i;
	// own loop index for the pin process, so no variable has two driving processes
	integer     j;

	// phase length in units for a given state
	function [5:0] phase_len;
		input [2:0]  st;
		input [14:0] cfg;
		input        wchg;
		begin
			case (st)
				ST_AB:   phase_len = 6'h01 + {5'h00, cfg[`EBCS_T_AB]}
					+ (wchg ? {4'h0, cfg[`EBCS_T_ABX_MSB:`EBCS_T_ABX_LSB]} : 6'h00);
				ST_C:    phase_len = {4'h0, cfg[`EBCS_T_CMD_MSB:`EBCS_T_CMD_LSB]};
				ST_D:    phase_len = {5'h00, cfg[`EBCS_T_WS]};
				ST_E:    phase_len = {1'b0, cfg[`EBCS_T_ACC_MSB:`EBCS_T_ACC_LSB]} + 6'h01;
				ST_F:    phase_len = {4'h0, cfg[`EBCS_T_HOLD_MSB:`EBCS_T_HOLD_LSB]};
				ST_RDY:  phase_len = 6'h01;
				default: phase_len = 6'h00;
			endcase
		end
	endfunction

	// successor phase, zero-length phases skipped
	function [2:0] next_phase;
		input [2:0]  st;
		input [14:0] cfg;
		begin
			case (st)
				ST_AB:   next_phase = (phase_len(ST_C, cfg, 1'b0) != 6'h00) ? ST_C :
					(cfg[`EBCS_T_WS] ? ST_D : ST_E);
				ST_C:    next_phase = cfg[`EBCS_T_WS] ? ST_D : ST_E;
				ST_D:    next_phase = ST_E;
				ST_E:    next_phase = (phase_len(ST_F, cfg, 1'b0) != 6'h00) ? ST_F : ST_IDLE;
				ST_RDY:  next_phase = (phase_len(ST_F, cfg, 1'b0) != 6'h00) ? ST_F : ST_IDLE;
				default: next_phase = ST_IDLE;
			endcase
		end
	endfunction

	// request decode
	wire        wr_cmd   = wr_i && (addr_i == `EBCS_OFF_CMD);
	wire        start    = wr_cmd && (state_reg == ST_IDLE);
	wire [CSW-1:0] cmd_cs = wdata_i[`EBCS_CMD_CS_LSB +: CSW];
	wire        wchg     = !last_valid_reg || (cmd_cs != last_cs_reg);
	wire [5:0]  tim_idx  = addr_i[7:2] - TIM_BASE[7:2];
	wire        tim_hit  = (addr_i[7:5] == TIM_BASE[7:5]) && (tim_idx < NCS);

	// ready selection and polarity
	wire        rdy_async = cfg_reg[`EBCS_T_RDY_ASYNC];
	wire        rdy_raw   = rdy_async ? rdy_sync : ready_i;
	wire        rdy_act   = rdy_raw ^ ctrl_reg[`EBCS_CTRL_RDY_LOW];

	// asynchronous ready passes two flops first
	ebcs_sync2 u_rdy_sync (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.async_i  (ready_i),
		.sync_o   (rdy_sync)
	);

	// phase time unit divider; restarts with each cycle so units align to the start
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tick_cnt_reg <= 16'h0000;
			tick_reg     <= 1'b0;
		end else if (start || tick_cnt_reg == TCS_DIV[15:0] - 16'h0001) begin
			tick_cnt_reg <= 16'h0000;
			tick_reg     <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 16'h0001;
			tick_reg     <= 1'b0;
		end
	end

	// phase sequencer
	always @* begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			ST_IDLE: begin
				if (start) begin
					state_next = ST_AB;
					cnt_next   = phase_len(ST_AB, timing_reg[cmd_cs], wchg);
				end
			end
			ST_AB, ST_C, ST_D, ST_E, ST_RDY, ST_F: begin
				if (tick_reg) begin
					if (cnt_reg > 6'h01) begin
						cnt_next = cnt_reg - 6'h01;
					end else if (state_reg == ST_E && cfg_reg[`EBCS_T_RDY_EN]
						&& (rdy_async || !rdy_act)) begin
						// async always waits once for the synchroniser
						state_next = ST_RDY;
						cnt_next   = 6'h01;
					end else if (state_reg == ST_RDY && !rdy_act) begin
						cnt_next = 6'h01;
					end else begin
						state_next = next_phase(state_reg, cfg_reg);
						cnt_next   = phase_len(state_next, cfg_reg, 1'b0);
					end
				end
			end
			default: begin
				state_next = ST_IDLE;
				cnt_next   = 6'h00;
			end
		endcase
	end

	// values in force for the cycle being set up
	wire           act_n   = (state_next != ST_IDLE);
	wire           strb_n  = (state_next == ST_D) || (state_next == ST_E) || (state_next == ST_RDY);
	wire           data_ph = strb_n || (state_next == ST_F);
	wire           adr_ph  = (state_next == ST_AB) || (state_next == ST_C);
	wire           dir_n   = start ? wdata_i[`EBCS_CMD_WRITE] : dir_wr_reg;
	wire           byte_n  = start ? wdata_i[`EBCS_CMD_BYTE] : byte_reg;
	wire [CSW-1:0] cs_n    = start ? cmd_cs : cs_reg;
	wire [23:0]    addr_n  = start ? addr_reg : addr_reg;
	wire           multiplexed_mode     = ctrl_reg[`EBCS_CTRL_MUX];
	wire           acc_end = (state_reg == ST_E || state_reg == ST_RDY)
		&& !(state_next == ST_E || state_next == ST_RDY);

	// state, cycle context and captured read data
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg      <= ST_IDLE;
			cnt_reg        <= 6'h00;
			cfg_reg        <= `EBCS_TIMING_RST;
			dir_wr_reg     <= 1'b0;
			byte_reg       <= 1'b0;
			cs_reg         <= {CSW{1'b0}};
			last_cs_reg    <= {CSW{1'b0}};
			last_valid_reg <= 1'b0;
			rdata_reg      <= 16'h0000;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			if (start) begin
				cfg_reg        <= timing_reg[cmd_cs];
				dir_wr_reg     <= dir_n;
				byte_reg       <= byte_n;
				cs_reg         <= cmd_cs;
				last_cs_reg    <= cmd_cs;
				last_valid_reg <= 1'b1;
			end
			// sampled as the strobe rises; later address moves cannot reach it
			if (acc_end && !dir_wr_reg) begin
				rdata_reg <= multiplexed_mode ? shared_addr_data_lines_i : separate_data_lines_i;
			end
		end
	end

	// software registers
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_reg  <= `EBCS_CTRL_RST;
			addr_reg  <= 24'h000000;
			wdata_reg <= 16'h0000;
			for (i = 0; i < NCS; i = i + 1) begin
				timing_reg[i] <= `EBCS_TIMING_RST;
			end
		end else if (wr_i) begin
			// address and data are frozen while a cycle runs
			if (addr_i == `EBCS_OFF_ADDR && state_reg == ST_IDLE) begin
				addr_reg <= wdata_i[23:0];
			end
			if (addr_i == `EBCS_OFF_WDATA && state_reg == ST_IDLE) begin
				wdata_reg <= wdata_i[15:0];
			end
			if (addr_i == `EBCS_OFF_CTRL) begin
				ctrl_reg <= wdata_i[3:0];
			end
			if (tim_hit) begin
				timing_reg[tim_idx[CSW-1:0]] <= wdata_i[14:0];
			end
		end
	end

	// read port, data valid only the cycle after the strobe
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_o <= 32'h00000000;
		end else if (!rd_i) begin
			rdata_o <= 32'h00000000;
		end else if (tim_hit) begin
			rdata_o <= {17'h00000, timing_reg[tim_idx[CSW-1:0]]};
		end else begin
			case (addr_i)
				`EBCS_OFF_ADDR:   rdata_o <= {8'h00, addr_reg};
				`EBCS_OFF_WDATA:  rdata_o <= {16'h0000, wdata_reg};
				`EBCS_OFF_RDATA:  rdata_o <= {16'h0000, rdata_reg};
				`EBCS_OFF_STATUS: rdata_o <= {{(32-CSW-5){1'b0}}, last_cs_reg, 1'b0, state_reg,
					(state_reg != ST_IDLE)};
				`EBCS_OFF_CTRL:   rdata_o <= {28'h0000000, ctrl_reg};
				default:          rdata_o <= 32'h00000000;
			endcase
		end
	end

	// pin drivers, all registered; bus controls from the next phase, clock enable from control
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			address_lines_o               <= 24'h000000;
			separate_data_lines_o         <= 16'h0000;
			separate_data_lines_oe_n_o    <= 1'b1;
			shared_addr_data_lines_o      <= 16'h0000;
			shared_addr_data_lines_oe_n_o <= 1'b1;
			cs_n_o                        <= {NCS{1'b1}};
			rd_n_o                        <= 1'b1;
			wr_n_o                        <= 1'b1;
			ale_o                         <= 1'b0;
			upper_byte_enable_n_o         <= 1'b1;
			reference_clock_out_en_o      <= 1'b0;
		end else begin
			// pad gates the system clock, so the period equals one clock
			reference_clock_out_en_o <= ctrl_reg[`EBCS_CTRL_CLK_SYS] && ctrl_reg[`EBCS_CTRL_HS_DRV];
			for (j = 0; j < NCS; j = j + 1) begin
				cs_n_o[j] <= !(act_n && cs_n == j[CSW-1:0]);
			end
			address_lines_o       <= addr_n;
			upper_byte_enable_n_o <= !(act_n && !(byte_n && !addr_n[0]));
			rd_n_o                <= !(strb_n && !dir_n);
			wr_n_o                <= !(strb_n && dir_n);
			ale_o                 <= multiplexed_mode && (state_next == ST_AB);
			// multiplexed lines: address first, then write data or released
			if (multiplexed_mode && adr_ph) begin
				shared_addr_data_lines_o      <= addr_n[15:0];
				shared_addr_data_lines_oe_n_o <= 1'b0;
			end else if (multiplexed_mode && data_ph && dir_n) begin
				shared_addr_data_lines_o      <= wdata_reg;
				shared_addr_data_lines_oe_n_o <= 1'b0;
			end else begin
				shared_addr_data_lines_o      <= 16'h0000;
				shared_addr_data_lines_oe_n_o <= 1'b1;
			end
			separate_data_lines_o      <= wdata_reg;
			separate_data_lines_oe_n_o <= !(!multiplexed_mode && data_ph && dir_n);
		end
	end

endmodule // ebcs_top

// *** testbench/ebcs_checker.sv ***
// pin-level assertions for the bus cycle sequencer
`timescale 1ns/10ps
module ebcs_checker #(
	parameter NCS = 4
) (
	// clock and reset
	input wire           clk_i,
	input wire           resetn_i,
	// watched bus pins
	input wire [NCS-1:0] cs_n_o,
	input wire           rd_n_o,
	input wire           wr_n_o,
	input wire           ale_o,
	input wire           separate_data_lines_oe_n_o,
	input wire           shared_addr_data_lines_oe_n_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// strobes only inside a selected cycle
	property p_in_cycle; (!rd_n_o || !wr_n_o) |-> !(&cs_n_o); endproperty
	a_in_cycle: assert property (p_in_cycle)
		else $error("strobe outside chip select");
	// setup plus command delay is at most 8 units
	property p_setup; $fell(&cs_n_o) |-> (rd_n_o && wr_n_o) ##[1:8] (!rd_n_o || !wr_n_o); endproperty
	a_setup: assert property (p_setup)
		else $error("strobe not within setup bound");
	property p_access; $fell(wr_n_o) |-> ##[1:33] $rose(wr_n_o); endproperty
	a_access: assert property (p_access)
		else $error("write strobe too long");
	property p_hold; $rose(rd_n_o) || $rose(wr_n_o) |-> ##[0:3] (&cs_n_o); endproperty
	a_hold: assert property (p_hold)
		else $error("hold phase too long");
	property p_ale; ale_o |-> rd_n_o && wr_n_o && !shared_addr_data_lines_oe_n_o; endproperty
	a_ale: assert property (p_ale)
		else $error("latch enable outside address setup");
	property p_rd_free; !rd_n_o |-> separate_data_lines_oe_n_o && shared_addr_data_lines_oe_n_o; endproperty
	a_rd_free: assert property (p_rd_free)
		else $error("data lines driven during read");
	property p_wr_drive; !wr_n_o |-> !(separate_data_lines_oe_n_o && shared_addr_data_lines_oe_n_o); endproperty
	a_wr_drive: assert property (p_wr_drive)
		else $error("write data not driven");
	property p_excl; !(!rd_n_o && !wr_n_o); endproperty
	a_excl: assert property (p_excl)
		else $error("both strobes low");
	c_wr: cover property ($rose(wr_n_o));
	c_rd: cover property ($rose(rd_n_o));
	c_ale: cover property ($rose(ale_o));
endmodule // ebcs_checker

// *** testbench/ebcs_mem_model.sv ***
// external memory model: read data and ready handshake
`timescale 1ns/10ps
module ebcs_mem_model (
	// clock and strobes
	input  wire        clk_i,
	input  wire        rd_n_i,
	input  wire        wr_n_i,
	// knobs
	input  wire [15:0] data_i,
	input  wire [7:0]  wait_i,
	input  wire        low_i,
	// answers
	output wire [15:0] data_o,
	output reg         ready_o
);
	reg [7:0] cnt_reg = 8'h00;
	// released lines show the inverse, so a late capture is seen
	assign data_o = rd_n_i ? ~data_i : data_i;
	// ready after wait_i strobe cycles, dropped when the strobe ends
	always @(posedge clk_i) begin
		cnt_reg <= (rd_n_i && wr_n_i) ? 8'h00 : cnt_reg + 8'h01;
		ready_o <= low_i ^ (!(rd_n_i && wr_n_i) && cnt_reg >= wait_i);
	end
	initial ready_o = 1'b0;
endmodule // ebcs_mem_model

// *** testbench/test_external_bus_cycle_sequencer.sv ***
// self-checking bench for the bus cycle sequencer
`timescale 1ns/10ps
module test_external_bus_cycle_sequencer;
	// clock, reset and register port
	reg         clk_i = 1'b0;
	reg         resetn_i = 1'b0;
	reg  [7:0]  addr_i = 8'h00;
	reg  [31:0] wdata_i = 32'h0;
	reg         wr_i = 1'b0;
	reg         rd_i = 1'b0;
	wire [31:0] rdata_o;
	// bus pins
	wire [23:0] address_lines_o;
	wire [15:0] sep_d, sh_d, mem_d;
	wire [3:0]  cs_n_o;
	wire        sep_oe_n, sh_oe_n, rd_n_o, wr_n_o, ale_o, ube_n, refclk_en, ready;
	// partner knobs and bench state
	reg  [15:0] mdat = 16'h0;
	reg  [7:0]  mwait = 8'h00;
	reg         mlow = 1'b0;
	reg  [15:0] seen_a16, seen_d16, seen_m16;
	reg  [23:0] seen_a;
	reg         seen_ale, seen_ube;
	reg  [31:0] rv;
	int         num_errors = 0, n_compared = 0, pre, str, post;

	always #4 clk_i = ~clk_i;

	ebcs_top DUT (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .address_lines_o(address_lines_o), .separate_data_lines_o(sep_d),
		.separate_data_lines_oe_n_o(sep_oe_n), .shared_addr_data_lines_o(sh_d),
		.shared_addr_data_lines_oe_n_o(sh_oe_n), .cs_n_o(cs_n_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o),
		.ale_o(ale_o), .upper_byte_enable_n_o(ube_n), .reference_clock_out_en_o(refclk_en),
		.separate_data_lines_i(mem_d), .shared_addr_data_lines_i(mem_d), .ready_i(ready));
	ebcs_mem_model u_mem (.clk_i(clk_i), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .data_i(mdat), .wait_i(mwait),
		.low_i(mlow), .data_o(mem_d), .ready_o(ready));

	task close_out;
		$display("compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task cmp(input string nm, input [31:0] e, input [31:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wreg(input [7:0] a, input [31:0] d);
		addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		// let an edge pass so a following write never re-raises the strobe in this step
		@(posedge clk_i);
	endtask
	task rreg(input [7:0] a);
		addr_i <= a; rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		rv = rdata_o;
		@(posedge clk_i);
	endtask
	function [31:0] tw(input int b, e, c, w, a, h, re, ra);
		tw = {17'h0, ra[0], re[0], h[1:0], 5'(a - 1), w[0], c[1:0], e[1:0], b[0]};
	endfunction
	// start one cycle and count setup, strobe and hold cycles
	task run(input [3:0] cmd);
		int k;
		pre = 0; str = 0; post = 0; seen_ale = 1'b0;
		addr_i <= 8'h08;
		wdata_i <= {28'h0, cmd};
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		for (k = 0; k < 300; k++) begin
			#1;
			if (&cs_n_o) break;
			if (ale_o) begin seen_ale = 1'b1; seen_a16 = sh_d; end
			if (!rd_n_o || !wr_n_o) begin
				str++; seen_a = address_lines_o; seen_d16 = sep_d; seen_m16 = sh_d;
				seen_ube = ube_n;
			end else if (str == 0) pre++;
			else post++;
			@(posedge clk_i);
		end
		@(posedge clk_i);
		if (k == 300) begin num_errors++; close_out; end
	endtask

	task t_reset;
		cmp("idle_pins", 32'h1fb, {cs_n_o, rd_n_o, wr_n_o, ale_o, sep_oe_n, sh_oe_n});
		rreg(8'h20); cmp("timing_rst", 32'h08c9, rv);
		rreg(8'h14); cmp("ctrl_rst", 32'h0, rv);
		rreg(8'h40); cmp("unmapped", 32'h0, rv);
	endtask
	task t_default;
		wreg(8'h00, 32'h00123456);
		wreg(8'h04, 32'h0000beef);
		run(4'h1);
		cmp("setup", 3, pre);
		cmp("strobe", 4, str);
		cmp("hold", 1, post);
		cmp("addr", 32'h123456, seen_a);
		cmp("wdata", 32'hbeef, seen_d16);
		cmp("ube", 0, seen_ube);
		run(4'h9);
		cmp("ube_byte", 1, seen_ube);
		rreg(8'h00); cmp("addr_reg", 32'h123456, rv);
	endtask
	task t_phases;
		int cf[4][6] = '{'{0,3,0,1,1,0}, '{1,2,3,0,32,3}, '{0,1,2,1,7,2}, '{1,0,0,0,1,0}};
		int i, j, c;
		for (i = 0; i < 4; i++) begin
			c = 1 + i % 3;
			wreg(8'h20 + 8'(4 * c), tw(cf[i][0], cf[i][1], cf[i][2], cf[i][3], cf[i][4], cf[i][5], 0, 0));
			for (j = 0; j < 2; j++) begin
				mdat <= 16'h5a00 + 16'(i * 2 + j);
				run({1'b0, 2'(c), i[0]});
				cmp("setup", 1 + cf[i][0] + (j ? 0 : cf[i][1]) + cf[i][2], pre);
				cmp("strobe", cf[i][3] + cf[i][4], str);
				cmp("hold", cf[i][5], post);
				if (!i[0]) begin rreg(8'h0c); cmp("rdata", mdat, rv[15:0]); end
			end
		end
		// idle, last cycle went to select 1
		rreg(8'h10); cmp("status", 32'h20, rv);
	endtask
	task t_ready;
		int p, w;
		for (p = 0; p < 2; p++)
			for (w = 0; w < 6; w += 5) begin
				wreg(8'h14, p << 1);
				mlow <= p[0]; mwait <= 8'(w);
				wreg(8'h20, tw(0, 0, 0, 0, 2, 0, 1, 0));
				run(4'h0);
				if (w == 0) cmp("rdy_fast", 2, str);
				else cmp("rdy_slow", w + 2, str);
			end
		wreg(8'h20, tw(0, 0, 0, 0, 2, 0, 1, 1));
		mwait <= 8'h00;
		run(4'h0);
		cmp("rdy_async", 1, str >= 3 && str <= 8);
	endtask
	task t_mux;
		wreg(8'h14, 32'h1);
		wreg(8'h20, 32'h08c9);
		wreg(8'h00, 32'h0000abcd);
		wreg(8'h04, 32'h00001357);
		run(4'h1);
		cmp("ale", 1, seen_ale);
		cmp("mux_addr", 32'habcd, seen_a16);
		cmp("mux_wdata", 32'h1357, seen_m16);
		mdat <= 16'h6c39;
		run(4'h0);
		rreg(8'h0c); cmp("mux_rdata", 32'h6c39, rv[15:0]);
	endtask
	task t_refclk;
		int i;
		for (i = 0; i < 4; i++) begin
			wreg(8'h14, i << 2);
			repeat (2) @(posedge clk_i);
			cmp("refclk", i == 3, refclk_en);
		end
	endtask

	initial begin
		repeat (12) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		t_reset;
		t_default;
		t_phases;
		t_ready;
		t_mux;
		t_refclk;
		close_out;
	end
endmodule // test_external_bus_cycle_sequencer

bind ebcs_top ebcs_checker #(.NCS(NCS)) u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .cs_n_o(cs_n_o),
	.rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .ale_o(ale_o), .separate_data_lines_oe_n_o(separate_data_lines_oe_n_o),
	.shared_addr_data_lines_oe_n_o(shared_addr_data_lines_oe_n_o));
